// ---- hdl/dlb_defines.svh ----
/*
  Offsets, field positions, reset values and timing counts of the bridge.
  Assumes a 20 MHz mclk on both ends and inclusion by bare name.
*/
`ifndef DLB_DEFINES_SVH
`define DLB_DEFINES_SVH

`define DLB_ADDR_SRST 8'h09
`define DLB_ADDR_PLL 8'h0D
`define DLB_ADDR_LANES 8'h10
`define DLB_ADDR_FMT 8'h18
`define DLB_ADDR_MODE 8'h30
`define DLB_ADDR_ERR 8'hE5

`define DLB_BIT_SRST 0
`define DLB_BIT_PLL 0
`define DLB_BIT_RUN 7
`define DLB_BIT_B_LAYOUT 0
`define DLB_BIT_A_LAYOUT 1
`define DLB_BIT_A_WIDE 3

`define DLB_ERR_CLEAR_ALL 8'hFF
`define DLB_ERR_NONE 8'h00
`define DLB_RST_LANES 2'h3
`define DLB_RST_ERR 8'h00

`define DLB_FRAME_BITS 5'h11
`define DLB_ADDR_DONE_BITS 5'h08
`define DLB_LINK_HALF 4
`define DLB_LINK_HALF_MIN 4

`define DLB_PIX_MIN_MHZ 25
`define DLB_PIX_MAX_MHZ 154

`define DLB_MCLK_KHZ 20000
`define DLB_T_RESET_MS 10
`define DLB_T_EN_MS 10
`define DLB_T_PLL_MS 10
`define DLB_T_SRST_MS 10
`define DLB_T_STREAM_MS 5
`define DLB_T_CLEAR_MS 1
`define DLB_MS_TO_CYC(ms) ((ms) * `DLB_MCLK_KHZ)

`endif

// ---- hdl/dlb_pkg.sv ----
/*
  Types shared by both ends of the bridge link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dlb_pkg;

  typedef enum logic [1:0] {
    DLB_OUT_SINGLE,
    DLB_OUT_DUAL,
    DLB_OUT_SPLIT
  } dlb_out_mode_e;

  typedef enum logic [3:0] {
    DLB_H_IDLE,
    DLB_H_LANES,
    DLB_H_EN_LOW,
    DLB_H_EN_WAIT,
    DLB_H_CFG,
    DLB_H_PLL,
    DLB_H_PLL_WAIT,
    DLB_H_SRST,
    DLB_H_SRST_WAIT,
    DLB_H_STREAM_WAIT,
    DLB_H_CLEAR,
    DLB_H_CLEAR_WAIT,
    DLB_H_CHECK,
    DLB_H_RUN
  } dlb_host_state_e;

  typedef logic [23:0] dlb_pixel_t;

endpackage : dlb_pkg

// ---- hdl/dlb_link_if.sv ----
/*
  Pins between the controlling host and the bridge.
  Assumes the testbench joins one host and one device through it.
*/
`timescale 1ns/10ps
`default_nettype none

interface dlb_link_if;
  logic en;
  logic clk_hs;
  logic data_lp11;
  logic link_clk;
  logic cs_n;
  logic sda;
  logic sdo;
  logic pix_valid;
  logic [23:0] pix_data;
  logic hsync;
  logic vsync;

  modport host (
    output en, output clk_hs, output data_lp11, output link_clk, output cs_n, output sda,
    output pix_valid, output pix_data, output hsync, output vsync, input sdo
  );

  modport device (
    input en, input clk_hs, input data_lp11, input link_clk, input cs_n, input sda,
    input pix_valid, input pix_data, input hsync, input vsync, output sdo
  );
endinterface : dlb_link_if

`default_nettype wire

// ---- hdl/dlb_device.sv ----
/*
  Bridge end: pin synchronisers, serial configuration slave, error flags
  and the pixel formatter that feeds the two output links.
  Assumes the video lines share mclk with the host; the enable, lane-state
  and serial pins are asynchronous and are synchronised here.
*/
//
// Overview of operation
// - Enable low: shutdown, inputs ignored, outputs high-Z.
// - Host holds enable low at least 10 ms.
// - Clock lane HS, data lanes LP11 during reset.
// - Program all registers; bridge idle until then.
// - Host sets PLL enable, waits 10 ms.
// - Host sets soft reset, waits 10 ms.
// - Host starts HS stream, waits 5 ms.
// - Writing all-ones to error register clears flags.
// - Nonzero error readback restarts from lane step.
// - Host may lengthen every wait.
// - Dual link: odd pixels A, even B.
// - No video: zero pixels, syncs still carried.
// - Per-link format bit; alternate puts LSBs on pair four.
// - First format puts colour MSBs on pair four.
// - Link A narrow mode drops pair four: MSBs in first format, LSBs in alternate.
// - One to four lanes, 1 Gbps each.
// - Pixel clock between 25 and 154 MHz.
// - Dual, split or single link; four pairs each.
`timescale 1ns/10ps
`default_nettype none

`include "dlb_defines.svh"

module dlb_device
  import dlb_pkg::*;
#(
  parameter int PIXEL_CLK_MHZ = `DLB_PIX_MIN_MHZ
) (
  input wire logic mclk,
  input wire logic srst,
  dlb_link_if.device lnk,
  output logic [27:0] lvds_a,
  output logic [27:0] lvds_b,
  output logic lvds_strobe,
  output logic lvds_oe_n,
  output logic operating
);

  if (PIXEL_CLK_MHZ < `DLB_PIX_MIN_MHZ || PIXEL_CLK_MHZ > `DLB_PIX_MAX_MHZ) begin : g_bad_clk
    $error("pixel clock outside supported range");
  end

  // Pair four sits on the top seven bits; syncs and enable ride pair three.
  function automatic logic [27:0] dlb_pack(input dlb_pixel_t p, input logic hs, input logic vs,
                                           input logic de, input logic lsb_fmt, input logic wide);
    logic [5:0] r6;
    logic [5:0] g6;
    logic [5:0] b6;
    logic [6:0] y3;
    r6 = lsb_fmt ? p[23:18] : p[21:16];
    g6 = lsb_fmt ? p[15:10] : p[13:8];
    b6 = lsb_fmt ? p[7:2] : p[5:0];
    y3 = lsb_fmt ? {1'b0, p[1:0], p[9:8], p[17:16]} : {1'b0, p[7:6], p[15:14], p[23:22]};
    if (!wide) begin
      y3 = 7'h00;
    end
    return {y3, de, vs, hs, b6[5:2], b6[1:0], g6[5:1], g6[0], r6};
  endfunction : dlb_pack

  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  logic sclk_d_reg;
  logic [4:0] bit_cnt_reg;
  logic [16:0] shift_in_reg;
  logic [7:0] rd_sh_reg;
  logic pll_en_reg;
  logic reset_done_reg;
  logic a_layout_reg;
  logic b_layout_reg;
  logic a_wide_reg;
  logic [1:0] lanes_reg;
  dlb_out_mode_e mode_reg;
  logic [7:0] err_reg;
  logic [7:0] err_next;
  logic par_reg;
  dlb_pixel_t hold_reg;
  logic hs_d_reg;
  logic [27:0] lvds_a_reg;
  logic [27:0] lvds_b_reg;
  logic strobe_reg;

  wire [5:0] pin_raw = {lnk.en, lnk.clk_hs, lnk.data_lp11, lnk.link_clk, lnk.cs_n, lnk.sda};

  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_meta_reg <= 6'h00;
      pin_sync_reg <= 6'h00;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire en_s = pin_sync_reg[5];
  wire clkhs_s = pin_sync_reg[4];
  wire lp11_s = pin_sync_reg[3];
  wire sclk_s = pin_sync_reg[2];
  wire cs_s = pin_sync_reg[1];
  wire sda_s = pin_sync_reg[0];

  // enable low is a full reset
  wire hold = srst | ~en_s;
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire frame_live = ~cs_s & sclk_rise;
  wire addr_done = frame_live & (bit_cnt_reg == `DLB_ADDR_DONE_BITS);
  wire data_phase = frame_live & (bit_cnt_reg > `DLB_ADDR_DONE_BITS);
  wire last_bit = frame_live & (bit_cnt_reg == (`DLB_FRAME_BITS - 5'h01));
  wire wr_fire = last_bit & ~shift_in_reg[15];
  wire [7:0] wr_addr = shift_in_reg[14:7];
  wire [7:0] wr_data = {shift_in_reg[6:0], sda_s};
  wire [7:0] rd_addr = {shift_in_reg[6:0], sda_s};

  wire wr_srst = wr_fire & (wr_addr == `DLB_ADDR_SRST) & wr_data[`DLB_BIT_SRST];
  wire wr_pll = wr_fire & (wr_addr == `DLB_ADDR_PLL);
  wire wr_lanes = wr_fire & (wr_addr == `DLB_ADDR_LANES);
  wire wr_fmt = wr_fire & (wr_addr == `DLB_ADDR_FMT);
  wire wr_mode = wr_fire & (wr_addr == `DLB_ADDR_MODE) & (wr_data[1:0] != 2'h3);
  wire wr_err = wr_fire & (wr_addr == `DLB_ADDR_ERR);

  wire run = en_s & pll_en_reg & reset_done_reg;

  wire [7:0] rd_value =
    (rd_addr == `DLB_ADDR_PLL) ? {run, 6'h00, pll_en_reg} :
    (rd_addr == `DLB_ADDR_LANES) ? {6'h00, lanes_reg} :
    (rd_addr == `DLB_ADDR_FMT) ? {4'h0, a_wide_reg, 1'b0, a_layout_reg, b_layout_reg} :
    (rd_addr == `DLB_ADDR_MODE) ? {6'h00, mode_reg} :
    (rd_addr == `DLB_ADDR_ERR) ? err_reg : 8'h00;

  always_ff @(posedge mclk) begin
    if (hold) begin
      sclk_d_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      shift_in_reg <= 17'h00000;
      rd_sh_reg <= 8'h00;
    end else begin
      sclk_d_reg <= sclk_s;
      if (cs_s) begin
        bit_cnt_reg <= 5'h00;
      end else if (sclk_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        shift_in_reg <= {shift_in_reg[15:0], sda_s};
      end
      if (addr_done) begin
        rd_sh_reg <= rd_value;
      end else if (data_phase) begin
        rd_sh_reg <= {rd_sh_reg[6:0], 1'b0};
      end
    end
  end

  // lane count held for the receiver
  always_ff @(posedge mclk) begin
    if (hold) begin
      pll_en_reg <= 1'b0;
      reset_done_reg <= 1'b0;
      a_layout_reg <= 1'b0;
      b_layout_reg <= 1'b0;
      a_wide_reg <= 1'b0;
      lanes_reg <= `DLB_RST_LANES;
      mode_reg <= DLB_OUT_SINGLE;
    end else begin
      if (wr_pll) begin
        pll_en_reg <= wr_data[`DLB_BIT_PLL];
      end
      // A soft reset only takes when the PLL already runs.
      if (wr_pll & ~wr_data[`DLB_BIT_PLL]) begin
        reset_done_reg <= 1'b0;
      end else if (wr_srst) begin
        reset_done_reg <= pll_en_reg;
      end
      if (wr_fmt) begin
        a_layout_reg <= wr_data[`DLB_BIT_A_LAYOUT];
        b_layout_reg <= wr_data[`DLB_BIT_B_LAYOUT];
        a_wide_reg <= wr_data[`DLB_BIT_A_WIDE];
      end
      if (wr_lanes) begin
        lanes_reg <= wr_data[1:0];
      end
      if (wr_mode) begin
        mode_reg <= dlb_out_mode_e'(wr_data[1:0]);
      end
    end
  end

  wire ev_early = lnk.pix_valid & en_s & ~run;
  wire ev_lp = lnk.pix_valid & en_s & lp11_s;
  wire ev_clk = run & ~clkhs_s;
  wire [7:0] clear_mask = wr_err ? wr_data : 8'h00;

  // clear by mask, new events win
  always_comb begin
    err_next = (err_reg & ~clear_mask) | {5'h00, ev_clk, ev_lp, ev_early};
  end

  always_ff @(posedge mclk) begin
    if (hold) begin
      err_reg <= `DLB_RST_ERR;
    end else begin
      err_reg <= err_next;
    end
  end

  wire in_valid = lnk.pix_valid & run;
  wire hs = lnk.hsync & en_s;
  wire vs = lnk.vsync & en_s;
  wire dual = (mode_reg == DLB_OUT_DUAL);
  wire single = (mode_reg == DLB_OUT_SINGLE);
  wire dlb_pixel_t px = in_valid ? lnk.pix_data : 24'h000000;
  wire dlb_pixel_t a_src = (dual & par_reg) ? hold_reg : px;
  // odd pixel waits for its even partner
  wire emits = ~dual | (in_valid == par_reg);
  wire [27:0] a_word = dlb_pack(a_src, hs, vs, in_valid, a_layout_reg, a_wide_reg);
  wire [27:0] b_word = single ? 28'h0000000 : dlb_pack(px, hs, vs, in_valid, b_layout_reg, 1'b1);
  wire line_start = hs & ~hs_d_reg;

  always_ff @(posedge mclk) begin
    if (hold) begin
      par_reg <= 1'b0;
      hold_reg <= 24'h000000;
      hs_d_reg <= 1'b0;
      lvds_a_reg <= 28'h0000000;
      lvds_b_reg <= 28'h0000000;
      strobe_reg <= 1'b0;
    end else begin
      hs_d_reg <= hs;
      strobe_reg <= emits;
      if (emits) begin
        lvds_a_reg <= a_word;
        lvds_b_reg <= b_word;
      end
      if (line_start | ~dual) begin
        par_reg <= 1'b0;
      end else if (in_valid) begin
        par_reg <= ~par_reg;
        hold_reg <= lnk.pix_data;
      end
    end
  end

  assign lvds_a = lvds_a_reg;
  assign lvds_b = lvds_b_reg;
  assign lvds_strobe = strobe_reg;
  assign lvds_oe_n = ~en_s;
  assign operating = run;
  assign lnk.sdo = rd_sh_reg[7];

endmodule : dlb_device

`default_nettype wire

// ---- hdl/dlb_host.sv ----
/*
  Controlling end: runs the start-up sequence, programs the bridge over the
  serial pins and forwards the user video once the stream is started.
  Assumes the bridge answers on sdo within half a link-clock period.
*/
`timescale 1ns/10ps
`default_nettype none

`include "dlb_defines.svh"

module dlb_host
  import dlb_pkg::*;
#(
  parameter int T_RESET_CYC = `DLB_MS_TO_CYC(`DLB_T_RESET_MS),
  parameter int T_EN_CYC = `DLB_MS_TO_CYC(`DLB_T_EN_MS),
  parameter int T_PLL_CYC = `DLB_MS_TO_CYC(`DLB_T_PLL_MS),
  parameter int T_SRST_CYC = `DLB_MS_TO_CYC(`DLB_T_SRST_MS),
  parameter int T_STREAM_CYC = `DLB_MS_TO_CYC(`DLB_T_STREAM_MS),
  parameter int T_CLEAR_CYC = `DLB_MS_TO_CYC(`DLB_T_CLEAR_MS),
  parameter int LINK_HALF = `DLB_LINK_HALF
) (
  input wire logic mclk,
  input wire logic srst,
  dlb_link_if.host lnk,
  input wire logic start,
  input wire logic [1:0] cfg_mode,
  input wire logic [1:0] cfg_lanes,
  input wire logic cfg_a_layout,
  input wire logic cfg_b_layout,
  input wire logic cfg_a_wide,
  input wire logic vid_valid,
  input wire dlb_pixel_t vid_data,
  input wire logic vid_hsync,
  input wire logic vid_vsync,
  output logic init_done,
  output logic init_busy,
  output logic [7:0] err_value
);

  if (LINK_HALF < `DLB_LINK_HALF_MIN || LINK_HALF > 15 || T_RESET_CYC < 1 || T_CLEAR_CYC < 1) begin : g_bad
    $error("host timing parameters out of range");
  end

  dlb_host_state_e state_reg;
  logic [23:0] wait_reg;
  logic [1:0] cfg_idx_reg;
  logic en_reg;
  logic clkhs_reg;
  logic lp11_reg;
  logic busy_reg;
  logic done_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic [3:0] div_reg;
  logic [4:0] bit_cnt_reg;
  logic [16:0] tx_reg;
  logic [7:0] rx_reg;
  logic [1:0] sdo_sync_reg;
  logic [7:0] err_reg;
  logic pv_reg;
  dlb_pixel_t pd_reg;
  logic hs_reg;
  logic vs_reg;

  wire xfer_state = (state_reg == DLB_H_CFG) | (state_reg == DLB_H_PLL) | (state_reg == DLB_H_SRST) |
                    (state_reg == DLB_H_CLEAR) | (state_reg == DLB_H_CHECK);
  wire go = xfer_state & ~busy_reg & ~done_reg;
  wire wait_over = (wait_reg == 24'h000000);
  wire [7:0] cfg_addr = (cfg_idx_reg == 2'h0) ? `DLB_ADDR_LANES :
                        (cfg_idx_reg == 2'h1) ? `DLB_ADDR_FMT : `DLB_ADDR_MODE;
  wire [7:0] cfg_data = (cfg_idx_reg == 2'h0) ? {6'h00, cfg_lanes} :
                        (cfg_idx_reg == 2'h1) ? {4'h0, cfg_a_wide, 1'b0, cfg_a_layout, cfg_b_layout} :
                        {6'h00, cfg_mode};
  wire [16:0] cmd =
    (state_reg == DLB_H_CFG) ? {1'b0, cfg_addr, cfg_data} :
    (state_reg == DLB_H_PLL) ? {1'b0, `DLB_ADDR_PLL, 8'h01} :
    (state_reg == DLB_H_SRST) ? {1'b0, `DLB_ADDR_SRST, 8'h01} :
    (state_reg == DLB_H_CLEAR) ? {1'b0, `DLB_ADDR_ERR, `DLB_ERR_CLEAR_ALL} :
    {1'b1, `DLB_ADDR_ERR, 8'h00};
  wire half_tick = (div_reg == 4'(LINK_HALF - 1));

  // Serial engine: data changes on falling edges, sdo captured on rising ones.
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      div_reg <= 4'h0;
      bit_cnt_reg <= 5'h00;
      tx_reg <= 17'h00000;
      rx_reg <= 8'h00;
      sdo_sync_reg <= 2'h0;
    end else begin
      sdo_sync_reg <= {sdo_sync_reg[0], lnk.sdo};
      done_reg <= 1'b0;
      if (go) begin
        busy_reg <= 1'b1;
        cs_n_reg <= 1'b0;
        tx_reg <= cmd;
        div_reg <= 4'h0;
        bit_cnt_reg <= 5'h00;
      end else if (busy_reg) begin
        div_reg <= half_tick ? 4'h0 : div_reg + 4'h1;
        if (half_tick & ~sclk_reg) begin
          sclk_reg <= 1'b1;
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg > `DLB_ADDR_DONE_BITS) begin
            rx_reg <= {rx_reg[6:0], sdo_sync_reg[1]};
          end
        end else if (half_tick) begin
          sclk_reg <= 1'b0;
          tx_reg <= {tx_reg[15:0], 1'b0};
          if (bit_cnt_reg == `DLB_FRAME_BITS) begin
            cs_n_reg <= 1'b1;
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end
      end
    end
  end

  // every wait is a lower bound
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= DLB_H_IDLE;
      wait_reg <= 24'h000000;
      cfg_idx_reg <= 2'h0;
      en_reg <= 1'b0;
      clkhs_reg <= 1'b0;
      lp11_reg <= 1'b1;
      err_reg <= 8'h00;
    end else begin
      if (!wait_over) begin
        wait_reg <= wait_reg - 24'h000001;
      end
      case (state_reg)
        DLB_H_IDLE: begin
          if (start) begin
            state_reg <= DLB_H_LANES;
          end
        end
        // clock lane HS, data lanes LP11
        DLB_H_LANES: begin
          clkhs_reg <= 1'b1;
          lp11_reg <= 1'b1;
          en_reg <= 1'b0;
          wait_reg <= 24'(T_RESET_CYC - 1);
          state_reg <= DLB_H_EN_LOW;
        end
        DLB_H_EN_LOW: begin
          if (wait_over) begin
            en_reg <= 1'b1;
            wait_reg <= 24'(T_EN_CYC - 1);
            state_reg <= DLB_H_EN_WAIT;
          end
        end
        DLB_H_EN_WAIT: begin
          if (wait_over) begin
            cfg_idx_reg <= 2'h0;
            state_reg <= DLB_H_CFG;
          end
        end
        DLB_H_CFG: begin
          if (done_reg) begin
            cfg_idx_reg <= cfg_idx_reg + 2'h1;
            if (cfg_idx_reg == 2'h2) begin
              state_reg <= DLB_H_PLL;
            end
          end
        end
        DLB_H_PLL: begin
          if (done_reg) begin
            wait_reg <= 24'(T_PLL_CYC - 1);
            state_reg <= DLB_H_PLL_WAIT;
          end
        end
        DLB_H_PLL_WAIT: begin
          if (wait_over) begin
            state_reg <= DLB_H_SRST;
          end
        end
        DLB_H_SRST: begin
          if (done_reg) begin
            wait_reg <= 24'(T_SRST_CYC - 1);
            state_reg <= DLB_H_SRST_WAIT;
          end
        end
        DLB_H_SRST_WAIT: begin
          if (wait_over) begin
            lp11_reg <= 1'b0;
            wait_reg <= 24'(T_STREAM_CYC - 1);
            state_reg <= DLB_H_STREAM_WAIT;
          end
        end
        DLB_H_STREAM_WAIT: begin
          if (wait_over) begin
            state_reg <= DLB_H_CLEAR;
          end
        end
        DLB_H_CLEAR: begin
          if (done_reg) begin
            wait_reg <= 24'(T_CLEAR_CYC - 1);
            state_reg <= DLB_H_CLEAR_WAIT;
          end
        end
        DLB_H_CLEAR_WAIT: begin
          if (wait_over) begin
            state_reg <= DLB_H_CHECK;
          end
        end
        DLB_H_CHECK: begin
          if (done_reg) begin
            err_reg <= rx_reg;
            state_reg <= (rx_reg != `DLB_ERR_NONE) ? DLB_H_LANES : DLB_H_RUN;
          end
        end
        DLB_H_RUN: begin
          state_reg <= DLB_H_RUN;
        end
        default: begin
          state_reg <= DLB_H_IDLE;
        end
      endcase
    end
  end

  wire streaming = ~lp11_reg & en_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      pv_reg <= 1'b0;
      pd_reg <= 24'h000000;
      hs_reg <= 1'b0;
      vs_reg <= 1'b0;
    end else begin
      pv_reg <= vid_valid & streaming;
      pd_reg <= vid_data;
      hs_reg <= vid_hsync & streaming;
      vs_reg <= vid_vsync & streaming;
    end
  end

  assign lnk.en = en_reg;
  assign lnk.clk_hs = clkhs_reg;
  assign lnk.data_lp11 = lp11_reg;
  assign lnk.link_clk = sclk_reg;
  assign lnk.cs_n = cs_n_reg;
  assign lnk.sda = tx_reg[16];
  assign lnk.pix_valid = pv_reg;
  assign lnk.pix_data = pd_reg;
  assign lnk.hsync = hs_reg;
  assign lnk.vsync = vs_reg;
  assign init_done = (state_reg == DLB_H_RUN);
  assign init_busy = (state_reg != DLB_H_RUN) & (state_reg != DLB_H_IDLE);
  assign err_value = err_reg;

endmodule : dlb_host

`default_nettype wire

// ---- bench/dlb_monitor.sv ----
/*
  Checker for the host side of the bridge link pins.
  Assumes the bench instantiates it beside the link, with the host reset as srst.
*/
`timescale 1ns/10ps
`default_nettype none

module dlb_monitor #(
  parameter int T_RESET_CYC = 50,
  parameter int T_EN_CYC = 50,
  parameter int T_PLL_CYC = 50,
  parameter int T_SRST_CYC = 50,
  parameter int T_STREAM_CYC = 50,
  parameter int T_CLEAR_CYC = 50
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic en,
  input wire logic clk_hs,
  input wire logic data_lp11,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic sda,
  input wire logic pix_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic lc_q;
  logic cs_q;
  logic [16:0] sh;
  int nb, c_lo, c_hi, c_pll, c_rst, c_hs, c_clr;
  wire fr_end = cs_n & ~cs_q & (nb == 17);
  wire wr_e5 = fr_end & ~sh[16] & (sh[15:8] == 8'hE5);
  wire wr_pll = fr_end & ~sh[16] & (sh[15:8] == 8'h0D) & sh[0];
  wire wr_rst = fr_end & ~sh[16] & (sh[15:8] == 8'h09) & sh[0];
  wire wr_clr = wr_e5 & (sh[7:0] == 8'hFF);
  wire rd_err = fr_end & sh[16] & (sh[15:8] == 8'hE5);
  // An age stays zero until its event is first seen, so a skipped step fails.
  function automatic int age(input logic ev, input int c);
    return ev ? 1 : ((c == 0) ? 0 : c + 1);
  endfunction : age
  always_ff @(posedge mclk) begin
    if (srst) begin
      lc_q <= 1'b0;
      cs_q <= 1'b1;
      nb <= 0;
    end else begin
      lc_q <= link_clk;
      cs_q <= cs_n;
      nb <= cs_n ? 0 : ((link_clk & ~lc_q) ? nb + 1 : nb);
    end
  end
  always_ff @(posedge mclk) begin
    if (link_clk & ~lc_q & ~cs_n) begin
      sh <= {sh[15:0], sda};
    end
  end
  always_ff @(posedge mclk) begin
    c_lo <= (srst | en) ? 0 : c_lo + 1;
    c_hi <= (srst | ~en) ? 0 : c_hi + 1;
    c_hs <= (srst | data_lp11) ? 0 : c_hs + 1;
    c_pll <= srst ? 0 : age(wr_pll, c_pll);
    c_rst <= srst ? 0 : age(wr_rst, c_rst);
    c_clr <= srst ? 0 : age(wr_clr, c_clr);
  end
  a_en_low_hold: assert property ($rose(en) |-> c_lo >= T_RESET_CYC - 1)
    else $error("enable raised too soon");
  a_lanes_in_reset: assert property ($rose(en) |-> clk_hs && data_lp11 && $past(clk_hs) && $past(data_lp11))
    else $error("lanes not ready at enable");
  a_lanes_lp11: assert property (!en |-> data_lp11)
    else $error("data lanes left idle state in reset");
  a_cfg_after_en: assert property ($fell(cs_n) |-> en && c_hi >= T_EN_CYC - 1)
    else $error("frame too soon after enable");
  a_pll_before_rst: assert property (wr_rst |-> c_pll >= T_PLL_CYC)
    else $error("soft reset before pll wait");
  a_rst_before_hs: assert property ($fell(data_lp11) |-> c_rst >= T_SRST_CYC)
    else $error("stream before soft reset wait");
  a_stream_wait: assert property (wr_clr |-> !data_lp11 && c_hs >= T_STREAM_CYC)
    else $error("error clear before stream wait");
  a_video_gated: assert property (pix_valid |-> !data_lp11 && c_rst > T_SRST_CYC)
    else $error("video before stream start");
  a_clear_all_ones: assert property (wr_e5 |-> sh[7:0] == 8'hFF)
    else $error("error clear not all ones");
  a_read_wait: assert property (rd_err |-> c_clr >= T_CLEAR_CYC)
    else $error("error read before clear wait");
endmodule : dlb_monitor

`default_nettype wire

// ---- bench/dsi_to_lvds_bridge_init_format_tb.sv ----
/*
  Bench: host and bridge joined by the link, user video in, LVDS words out.
  Assumes shortened host waits of 50 cycles and a 20 MHz mclk.
*/
`timescale 1ns/10ps
`default_nettype none

`include "dlb_defines.svh"

module dsi_to_lvds_bridge_init_format_tb
  import dlb_pkg::*;
;
  typedef struct packed {
    logic [27:0] a;
    logic [27:0] b;
  } dlb_note_s;
  localparam int T_W = 50;
  logic mclk, srst, host_srst, start, vid_valid, vid_hsync, vid_vsync, init_done, init_busy;
  logic cfg_a_layout, cfg_b_layout, cfg_a_wide, lvds_strobe, lvds_oe_n, operating;
  logic [1:0] cfg_mode, cfg_lanes;
  logic [7:0] err_value;
  logic [27:0] lvds_a, lvds_b;
  logic [31:0] seed;
  dlb_pixel_t vid_data;
  int n_errors, n_tests, cyc;
  dlb_note_s notes[$];
  dlb_note_s nt;
  dlb_link_if lnk();
  dlb_host #(.T_RESET_CYC(T_W), .T_EN_CYC(T_W), .T_PLL_CYC(T_W), .T_SRST_CYC(T_W), .T_STREAM_CYC(T_W),
    .T_CLEAR_CYC(T_W), .LINK_HALF(4)) u_dlb_host (.mclk(mclk), .srst(host_srst), .lnk(lnk), .start(start),
    .cfg_mode(cfg_mode), .cfg_lanes(cfg_lanes), .cfg_a_layout(cfg_a_layout), .cfg_b_layout(cfg_b_layout),
    .cfg_a_wide(cfg_a_wide), .vid_valid(vid_valid), .vid_data(vid_data), .vid_hsync(vid_hsync),
    .vid_vsync(vid_vsync), .init_done(init_done), .init_busy(init_busy), .err_value(err_value));
  dlb_device #(.PIXEL_CLK_MHZ(154)) u_dlb_device (.mclk(mclk), .srst(srst), .lnk(lnk), .lvds_a(lvds_a),
    .lvds_b(lvds_b), .lvds_strobe(lvds_strobe), .lvds_oe_n(lvds_oe_n), .operating(operating));
  dlb_monitor #(.T_RESET_CYC(T_W), .T_EN_CYC(T_W), .T_PLL_CYC(T_W), .T_SRST_CYC(T_W), .T_STREAM_CYC(T_W),
    .T_CLEAR_CYC(T_W)) u_dlb_monitor (.mclk(mclk), .srst(host_srst), .en(lnk.en), .clk_hs(lnk.clk_hs),
    .data_lp11(lnk.data_lp11), .link_clk(lnk.link_clk), .cs_n(lnk.cs_n), .sda(lnk.sda),
    .pix_valid(lnk.pix_valid));

  always #25 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [27:0] word(input dlb_pixel_t p, input logic lay, input logic wide, input logic [2:0] sy);
    logic [5:0] r, g, b;
    logic [6:0] y;
    r = lay ? p[23:18] : p[21:16];
    g = lay ? p[15:10] : p[13:8];
    b = lay ? p[7:2] : p[5:0];
    y = lay ? {1'b0, p[1:0], p[9:8], p[17:16]} : {1'b0, p[7:6], p[15:14], p[23:22]};
    return {wide ? y : 7'h00, sy, b, g, r};
  endfunction : word

  task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic note(input logic [27:0] a, input logic [27:0] b, input logic bon);
    notes.push_back({a, bon ? b : 28'h0000000});
  endtask : note

  task automatic drv(input logic v, input dlb_pixel_t d, input logic [1:0] sy);
    @(posedge mclk);
    vid_valid <= v;
    vid_data <= d;
    vid_vsync <= sy[1];
    vid_hsync <= sy[0];
  endtask : drv

  task automatic run_cfg(input logic [1:0] md, input logic la, input logic lb, input logic wd, input logic [1:0] ln);
    dlb_pixel_t p, q;
    int k;
    @(posedge mclk);
    host_srst <= 1'b1;
    cfg_mode <= md;
    cfg_a_layout <= la;
    cfg_b_layout <= lb;
    cfg_a_wide <= wd;
    cfg_lanes <= ln;
    repeat (4) @(posedge mclk);
    host_srst <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("output disable", 28'h1, {27'h0, lvds_oe_n});
    chk("operating", 28'h0, {27'h0, operating});
    start <= 1'b1;
    for (k = 0; k < 20000 && lnk.cs_n !== 1'b0; k++) @(posedge mclk);
    chk("operating before setup", 28'h0, {27'h0, operating});
    chk("busy in setup", 28'h1, {27'h0, init_busy});
    for (k = 0; k < 20000 && init_done !== 1'b1; k++) @(posedge mclk);
    start <= 1'b0;
    chk("error readback", {20'h0, `DLB_ERR_NONE}, {20'h0, err_value});
    chk("running", 28'h3, {26'h0, operating, ~lvds_oe_n});
    chk("busy after setup", 28'h0, {27'h0, init_busy});
    drv(1'b0, 24'h0, 2'b01);
    note(word(24'h0, la, wd, 3'b001), word(24'h0, lb, 1'b1, 3'b001), md != 2'h0);
    drv(1'b0, 24'h0, 2'b10);
    note(word(24'h0, la, wd, 3'b010), word(24'h0, lb, 1'b1, 3'b010), md != 2'h0);
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      p = seed[23:0];
      drv(1'b1, p, 2'b00);
      if (md == 2'h1 && k[0]) note(word(q, la, wd, 3'b100), word(p, lb, 1'b1, 3'b100), 1'b1);
      else if (md != 2'h1) note(word(p, la, wd, 3'b100), word(p, lb, 1'b1, 3'b100), md == 2'h2);
      q = p;
    end
    drv(1'b0, 24'h0, 2'b00);
    repeat (8) @(posedge mclk);
    chk("notes left", 28'h0, 28'(notes.size()));
    $display("test mode %0d done", md);
  endtask : run_cfg

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // An empty queue yields all ones, so a stray word cannot pass.
  always @(posedge mclk) begin
    if (lvds_strobe === 1'b1 && (lvds_a | lvds_b) !== 28'h0) begin
      nt = (notes.size() > 0) ? notes.pop_front() : '1;
      chk("link a word", nt.a, lvds_a);
      chk("link b word", nt.b, lvds_b);
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("MISMATCH watchdog expected done seen hang");
      finish_test();
    end
  end

  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    host_srst = 1'b1;
    start = 1'b0;
    cfg_mode = 2'h0;
    cfg_lanes = 2'h3;
    cfg_a_layout = 1'b0;
    cfg_b_layout = 1'b0;
    cfg_a_wide = 1'b1;
    vid_valid = 1'b0;
    vid_data = 24'h000000;
    vid_hsync = 1'b0;
    vid_vsync = 1'b0;
    seed = 32'h8634;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    host_srst <= 1'b0;
    run_cfg(2'h1, 1'b1, 1'b0, 1'b1, 2'h3);
    run_cfg(2'h0, 1'b1, 1'b0, 1'b0, 2'h0);
    run_cfg(2'h2, 1'b0, 1'b1, 1'b1, 2'h1);
    finish_test();
  end
endmodule : dsi_to_lvds_bridge_init_format_tb

`default_nettype wire
